// ==== pkg/rms_pkg.sv ====
// Package: shared constants and types for the radio mode startup sequencer
package rms_pkg;
  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  // ----------------------------------------
  // Timing (clock 100 MHz, times in ns)
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int OSC_WAKE_NS = 200;
  localparam int OSC_WAKE_CYC = (OSC_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TX_BASE_NS = 5000;
  localparam int TX_BASE_CYC = (TX_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FE_DELAY_NS = 20000;
  localparam int FE_DELAY_CYC = (FE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOOP_BW_KHZ = 300;
  localparam int RELOCK_NUM = 5;
  localparam int RELOCK_CYC = (RELOCK_NUM * 1000000 + LOOP_BW_KHZ * CLK_NS - 1) / (LOOP_BW_KHZ * CLK_NS);
  localparam int CF_FSK_NUM = 21;
  localparam int CF_OOK_NUM = 34;
  localparam int AFC_BITS = 4;
  localparam int SYNC_LOCK_BITS = 12;
  localparam int RAMP_NUM = 5;
  localparam int RAMP_DEN = 4;
  localparam int CNT_W = 24;
  localparam int BW_W = 20;
  // Receive bandwidth given in kHz, bit period in clock cycles
  localparam logic [19:0] BW_KHZ_RST = 20'h00064;
  typedef enum logic [3:0] {
    RMS_IDLE, RMS_OSC, RMS_LOCK, RMS_TXWAIT, RMS_TXON, RMS_FE, RMS_CF, RMS_DCC,
    RMS_RSSI, RMS_AFC, RMS_RELOCK, RMS_CF2, RMS_RXON
  } rms_state_t;
endpackage

// ==== pkg/rms_link_if.sv ====
// Interface: pins between transceiver sequencer and host
interface rms_link_if;
  logic data_dev_o;
  logic data_dev_oe;
  logic data_host_o;
  logic data_host_oe;
  logic bit_clock_pin;
  logic mode_settled_flag;
  logic transmit_ready_flag;
  logic receive_ready_flag;
  logic [2:0] mode_req;
  logic sequencer_disable;
  logic serial_data_pin;
  assign serial_data_pin = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 1'b0);
  modport dev (input mode_req, input sequencer_disable, input data_host_o, input data_host_oe,
    output data_dev_o, output data_dev_oe, output bit_clock_pin, output mode_settled_flag,
    output transmit_ready_flag, output receive_ready_flag);
  modport host (output mode_req, output sequencer_disable, output data_host_o, output data_host_oe,
    input data_dev_o, input data_dev_oe, input bit_clock_pin, input mode_settled_flag,
    input transmit_ready_flag, input receive_ready_flag);
endinterface

// ==== hw/rms_device.sv ====
// Device end: mode sequencer with transmitter and receiver startup timing
module rms_device
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link
  rms_link_if.dev link,
  // Configuration
  input wire logic ook_i,
  input wire logic packet_mode_i,
  input wire logic bit_sync_on_i,
  input wire logic afc_on_i,
  input wire logic [15:0] bit_cycles_i,
  input wire logic [15:0] ramp_cycles_i,
  input wire logic [19:0] bw_khz_i,
  input wire logic start_trigger_i,
  input wire logic rx_bit_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic synth_locked_i,
  // Status
  output logic tx_byte_taken_o,
  output logic rx_data_o,
  output logic rx_data_valid_o
);
  // ----------------------------------------
  // Delay arithmetic
  // ----------------------------------------
  // Cycles of n/(4*BW) with BW in kHz: n*1e6/(4*BW*10ns), rounded up
  function automatic logic [CNT_W-1:0] over_4bw(input int unsigned n, input logic [19:0] bw);
    logic [39:0] num;
    logic [39:0] den;
    num = 40'(n) * 40'd100000;
    den = (bw == 20'h0) ? 40'd4 : 40'(bw) * 40'd4;
    over_4bw = CNT_W'((num + den - 40'd1) / den);
  endfunction
  logic [39:0] prod;
  logic [CNT_W-1:0] cf_cyc, dcc_cyc, rssi_cyc, tx_cyc;
  int unsigned k, p;
  always_comb begin
    // 4*BW*Tbit = 4*bw_khz*bit_cycles*1e-5
    prod = (40'(bw_khz_i) * 40'(bit_cycles_i) * 40'd4) / 40'd100000;
    k = 32'(prod[31:0]);
    p = 1;
    while (p < 2 * k && p < 32'h10000) p = p * 2; // power of two near 8*BW*Tbit
    cf_cyc = over_4bw(ook_i ? CF_OOK_NUM : CF_FSK_NUM, bw_khz_i);
    dcc_cyc = over_4bw((p > 8) ? p : 8, bw_khz_i);
    rssi_cyc = over_4bw((2 * k == 0) ? 1 : 2 * k, bw_khz_i);
    tx_cyc = CNT_W'(TX_BASE_CYC) + CNT_W'((32'(ramp_cycles_i) * RAMP_NUM + RAMP_DEN - 1) / RAMP_DEN)
      + CNT_W'(bit_cycles_i >> 1);
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  rms_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [1:0] rssi_n_r, rssi_n_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic lock_s1_r, lock_s2_r;
  logic done;
  assign done = (cnt_r == '0);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = done ? cnt_r : cnt_r - CNT_W'(1);
    rssi_n_nxt = rssi_n_r;
    mode_nxt = link.mode_req;
    if (link.mode_req != mode_r) begin
      // New request restarts the sequence; direct entry when sequencer disabled
      if (link.sequencer_disable) begin
        st_nxt = (link.mode_req == MODE_TX) ? RMS_TXON : (link.mode_req == MODE_RX) ? RMS_RXON : RMS_IDLE;
      end else if (link.mode_req == MODE_SLEEP) begin
        st_nxt = RMS_IDLE;
      end else if (mode_r == MODE_SLEEP) begin
        st_nxt = RMS_OSC;
        cnt_nxt = CNT_W'(OSC_WAKE_CYC);
      end else begin
        st_nxt = RMS_LOCK;
      end
    end else begin
      case (st_r)
        RMS_OSC: if (done) st_nxt = RMS_LOCK;
        RMS_LOCK: begin
          if (lock_s2_r && (mode_r == MODE_TX)) begin
            st_nxt = RMS_TXWAIT;
            cnt_nxt = tx_cyc;
          end else if (lock_s2_r && (mode_r == MODE_RX)) begin
            st_nxt = RMS_FE;
            cnt_nxt = CNT_W'(FE_DELAY_CYC);
          end
        end
        RMS_TXWAIT: if (done) st_nxt = RMS_TXON;
        RMS_FE: if (done) begin
          st_nxt = RMS_CF;
          cnt_nxt = cf_cyc;
        end
        RMS_CF: if (done) begin
          st_nxt = RMS_DCC;
          cnt_nxt = dcc_cyc;
        end
        RMS_DCC: if (done) begin
          st_nxt = RMS_RSSI;
          cnt_nxt = rssi_cyc;
          rssi_n_nxt = 2'h0;
        end
        RMS_RSSI: if (done) begin
          if (!afc_on_i || rssi_n_r == 2'h1) begin
            st_nxt = afc_on_i ? RMS_AFC : RMS_RXON;
            cnt_nxt = CNT_W'(32'(bit_cycles_i) * AFC_BITS);
          end else begin
            rssi_n_nxt = rssi_n_r + 2'h1;
            cnt_nxt = rssi_cyc;
          end
        end
        RMS_AFC: if (done) begin
          st_nxt = RMS_RELOCK;
          cnt_nxt = CNT_W'(RELOCK_CYC);
        end
        RMS_RELOCK: if (done) begin
          st_nxt = RMS_CF2;
          cnt_nxt = cf_cyc + dcc_cyc;
        end
        RMS_CF2: if (done) st_nxt = RMS_RXON;
        RMS_IDLE, RMS_TXON, RMS_RXON: st_nxt = st_r;
        default: st_nxt = RMS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= RMS_IDLE;
      cnt_r <= '0;
      rssi_n_r <= 2'h0;
      mode_r <= MODE_SLEEP;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rssi_n_r <= rssi_n_nxt;
      mode_r <= mode_nxt;
      lock_s1_r <= synth_locked_i;
      lock_s2_r <= lock_s1_r;
    end
  end
  // ----------------------------------------
  // Flags and data path
  // ----------------------------------------
  logic [15:0] bc_r, bc_nxt;
  logic clk_r, clk_nxt, sent_r, sent_nxt, dat_r, dat_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic taken;
  logic tx_on, rx_on;
  assign tx_on = (st_r == RMS_TXON);
  assign rx_on = (st_r == RMS_RXON);
  always_comb begin
    bc_nxt = bc_r + 16'h1;
    clk_nxt = clk_r;
    sent_nxt = sent_r;
    dat_nxt = dat_r;
    bit_nxt = bit_r;
    pre_nxt = pre_r;
    sh_nxt = sh_r;
    taken = 1'b0;
    if (!(tx_on || rx_on)) begin
      bc_nxt = 16'h0;
      clk_nxt = 1'b0;
      sent_nxt = 1'b0;
      bit_nxt = 3'h0;
      pre_nxt = 5'h0;
      sh_nxt = 8'hAA;
    end else if (bc_r >= (bit_cycles_i >> 1) - 16'h1) begin
      bc_nxt = 16'h0;
      clk_nxt = ~clk_r;
      if (clk_r) begin
        // Falling edge: next bit; host samples on rising edge
        bit_nxt = bit_r + 3'h1;
        if (tx_on && packet_mode_i) begin
          dat_nxt = sh_r[7];
          sh_nxt = {sh_r[6:0], 1'b0};
          if (bit_r == 3'h7) begin
            sh_nxt = (sent_r || start_trigger_i) ? tx_byte_i : 8'hAA;
            taken = sent_r || start_trigger_i;
            sent_nxt = sent_r | start_trigger_i;
          end
        end
      end else if (rx_on && pre_r != 5'h1F) begin
        pre_nxt = pre_r + 5'h1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bc_r <= 16'h0;
      clk_r <= 1'b0;
      sent_r <= 1'b0;
      dat_r <= 1'b0;
      bit_r <= 3'h0;
      pre_r <= 5'h0;
      sh_r <= 8'hAA;
    end else begin
      bc_r <= bc_nxt;
      clk_r <= clk_nxt;
      sent_r <= sent_nxt;
      dat_r <= dat_nxt;
      bit_r <= bit_nxt;
      pre_r <= pre_nxt;
      sh_r <= sh_nxt;
    end
  end
  // Flags are levels while the mode is fully up
  assign link.mode_settled_flag = tx_on || rx_on || (st_r == RMS_IDLE && !reset_i);
  assign link.transmit_ready_flag = tx_on;
  assign link.receive_ready_flag = rx_on;
  assign link.bit_clock_pin = clk_r;
  assign link.data_dev_o = dat_r;
  assign link.data_dev_oe = tx_on && packet_mode_i;
  assign tx_byte_taken_o = taken;
  // Unsynced continuous data is valid at once; otherwise after 12 preamble bits
  assign rx_data_o = rx_bit_i;
  assign rx_data_valid_o = rx_on && ((!packet_mode_i && !bit_sync_on_i)
    || (pre_r >= 5'(SYNC_LOCK_BITS)));
endmodule

// ==== hw/rms_host.sv ====
// Host end: requests modes and drives continuous transmit data on the bit clock
module rms_host
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link
  rms_link_if.host link,
  // User side
  input wire logic [2:0] mode_i,
  input wire logic hop_i,
  input wire logic tx_bit_i,
  input wire logic continuous_i,
  output logic bit_taken_o,
  output logic hop_done_o,
  output logic busy_o
);
  // ----------------------------------------
  // Pin synchronisers and hop sequence
  // ----------------------------------------
  logic [2:0] s1_r, s2_r;
  logic clk_d_r, dat_r, dat_nxt, oe_r, oe_nxt;
  logic [2:0] req_r, req_nxt;
  logic [1:0] hop_r, hop_nxt;
  logic [2:0] hold_r, hold_nxt;
  logic ready, rise;
  assign ready = s2_r[1] | s2_r[2];
  assign rise = s2_r[0] & ~clk_d_r;
  always_comb begin
    req_nxt = req_r;
    hop_nxt = hop_r;
    dat_nxt = dat_r;
    oe_nxt = continuous_i && ready && req_r == MODE_TX && hop_r == 2'h0 && hold_r == 3'h0;
    bit_taken_o = 1'b0;
    hop_done_o = 1'b0;
    case (hop_r)
      2'h0: begin
        req_nxt = mode_i;
        if (hop_i && (mode_i == MODE_TX || mode_i == MODE_RX)) begin
          hop_nxt = 2'h1;
          req_nxt = (mode_i == MODE_TX) ? MODE_RX : MODE_SYNTH;
        end
      end
      2'h1: hop_nxt = 2'h2; // carrier rewrite slot
      2'h2: begin
        req_nxt = mode_i;
        hop_nxt = 2'h0;
        hop_done_o = 1'b1;
      end
      default: hop_nxt = 2'h0;
    endcase
    // Synchronised flags still show the old mode for a few cycles after a new request
    hold_nxt = (req_nxt != req_r) ? 3'h4 : hold_r - {2'h0, hold_r != 3'h0};
    if (rise && oe_r) begin
      dat_nxt = tx_bit_i;
      bit_taken_o = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      clk_d_r <= 1'b0;
      dat_r <= 1'b0;
      oe_r <= 1'b0;
      req_r <= MODE_SLEEP;
      hop_r <= 2'h0;
      hold_r <= 3'h0;
    end else begin
      s1_r <= {link.transmit_ready_flag, link.mode_settled_flag, link.bit_clock_pin};
      s2_r <= s1_r;
      clk_d_r <= s2_r[0];
      dat_r <= dat_nxt;
      oe_r <= oe_nxt;
      req_r <= req_nxt;
      hop_r <= hop_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign link.mode_req = req_r;
  assign link.sequencer_disable = 1'b0;
  assign link.data_host_o = dat_r;
  assign link.data_host_oe = oe_r;
  assign busy_o = hop_r != 2'h0;
endmodule

// ==== test/rms_monitor.sv ====
// Checker: timing and handshake relations on the sequencer link
module rms_monitor
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link signals
  input wire logic data_dev_oe,
  input wire logic data_host_oe,
  input wire logic bit_clock_pin,
  input wire logic mode_settled_flag,
  input wire logic transmit_ready_flag,
  input wire logic receive_ready_flag,
  input wire logic [2:0] mode_req,
  input wire logic sequencer_disable
);
  // ----------------
  // Age of the current mode request
  // ----------------
  logic [2:0] prev_r;
  logic [2:0] prev_nxt;
  logic [15:0] age_r;
  logic [15:0] age_nxt;
  // Saturates so a long stay never wraps into a false early reading
  always_comb begin
    prev_nxt = mode_req;
    age_nxt = (mode_req != prev_r) ? 16'h0000 : age_r + {15'h0000, ~&age_r};
  end
  always_ff @(posedge clk_i) begin
    prev_r <= reset_i ? MODE_SLEEP : prev_nxt;
    age_r <= reset_i ? 16'h0000 : age_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------
  // Properties
  // ----------------
  property p_tx_wait;
    $rose(transmit_ready_flag) |-> age_r >= TX_BASE_CYC - 4;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("transmit ready too early");
  property p_tx_flags;
    $rose(transmit_ready_flag) |-> mode_settled_flag && mode_req == MODE_TX;
  endproperty
  a_tx_flags: assert property (p_tx_flags) else $error("transmit ready without settled");
  property p_rx_wait;
    $rose(receive_ready_flag) |-> age_r >= FE_DELAY_CYC;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("receive ready too early");
  property p_rx_flags;
    $rose(receive_ready_flag) |-> mode_settled_flag && mode_req == MODE_RX;
  endproperty
  a_rx_flags: assert property (p_rx_flags) else $error("receive ready without settled");
  property p_tx_drop;
    $changed(mode_req) && $past(mode_req) == MODE_TX |-> ##[1:3] !transmit_ready_flag;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("transmitter left on");
  // Four quiet samples give the clock divider time to park after a mode change
  property p_clk_still;
    (!transmit_ready_flag && !receive_ready_flag) [*4] |-> $stable(bit_clock_pin);
  endproperty
  a_clk_still: assert property (p_clk_still) else $error("bit clock runs while not ready");
  property p_oe_ready;
    $rose(data_host_oe) |-> transmit_ready_flag;
  endproperty
  a_oe_ready: assert property (p_oe_ready) else $error("host drives data before ready");
  property p_no_fight;
    !(data_dev_oe && data_host_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_seq_on;
    !sequencer_disable;
  endproperty
  a_seq_on: assert property (p_seq_on) else $error("sequencer disabled");
  // Main scenarios
  c_tx: cover property ($rose(transmit_ready_flag));
  c_rx: cover property ($rose(receive_ready_flag));
  c_oe: cover property ($rose(data_host_oe));
endmodule

// ==== test/testbench.sv ====
// Testbench: both sequencer ends joined by the link, driven through mode requests
module testbench
  import rms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // Signals and instances
  // ----------------
  localparam logic [15:0] BITC = 16'h0010;
  localparam logic [15:0] RAMPC = 16'h0008;
  logic clk_i, reset_i, ook, pkt, bsync, afc, trig, rxb, locked, hop, txb, cont, pb;
  logic [7:0] txbyte;
  logic [2:0] mode;
  logic taken, rxd, rxv, btaken, hdone, busy;
  int n_errors = 0;
  int checks_done = 0;
  int n, k, base;
  int takes = 0;
  int btakes = 0;
  logic [2:0] seen[$];
  rms_link_if lk();
  rms_device i_rms_device(.clk_i(clk_i), .reset_i(reset_i), .link(lk), .ook_i(ook), .packet_mode_i(pkt),
    .bit_sync_on_i(bsync), .afc_on_i(afc), .bit_cycles_i(BITC), .ramp_cycles_i(RAMPC), .bw_khz_i(20'h00190),
    .start_trigger_i(trig), .rx_bit_i(rxb), .tx_byte_i(txbyte), .synth_locked_i(locked),
    .tx_byte_taken_o(taken), .rx_data_o(rxd), .rx_data_valid_o(rxv));
  rms_host i_rms_host(.clk_i(clk_i), .reset_i(reset_i), .link(lk), .mode_i(mode), .hop_i(hop), .tx_bit_i(txb),
    .continuous_i(cont), .bit_taken_o(btaken), .hop_done_o(hdone), .busy_o(busy));
  rms_monitor i_rms_monitor(.clk_i(clk_i), .reset_i(reset_i), .data_dev_oe(lk.data_dev_oe),
    .data_host_oe(lk.data_host_oe), .bit_clock_pin(lk.bit_clock_pin), .mode_settled_flag(lk.mode_settled_flag),
    .transmit_ready_flag(lk.transmit_ready_flag), .receive_ready_flag(lk.receive_ready_flag),
    .mode_req(lk.mode_req), .sequencer_disable(lk.sequencer_disable));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Record each new mode request and count byte hand-offs
  always @(posedge clk_i) begin
    if (lk.mode_req !== seen[$]) seen.push_back(lk.mode_req);
    takes += (taken === 1'b1);
    btakes += (btaken === 1'b1);
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Request a mode and count cycles until its ready flag stands
  task automatic go(input logic [2:0] m);
    @(negedge clk_i);
    mode = m;
    n = 0;
    while (((m == MODE_TX) ? lk.transmit_ready_flag : lk.receive_ready_flag) !== 1'b1 && n < 30000) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic sleep();
    @(negedge clk_i);
    mode = MODE_SLEEP;
    repeat (4) @(negedge clk_i);
  endtask
  // Hop pulse lowered after one cycle; bounded wait for completion
  task automatic do_hop(input logic [8:0] order);
    base = seen.size() - 1;
    hop = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      hop = 1'b0;
      n++;
      if (n == 1) chk(busy, 1);
    end while (hdone !== 1'b1 && n < 100);
    repeat (2) @(negedge clk_i);
    chk({seen[base], seen[base + 1], seen[base + 2]}, order);
  endtask
  // Cuts a hang short
  initial begin
    #900000;
    n_errors++;
    results();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    reset_i = 1'b1; ook = 1'b0; pkt = 1'b0; bsync = 1'b0; afc = 1'b1; trig = 1'b0; rxb = 1'b0;
    locked = 1'b1; hop = 1'b0; txb = 1'b0; cont = 1'b1; txbyte = 8'h3C; mode = MODE_SLEEP;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk({lk.mode_settled_flag, lk.sequencer_disable}, 2'h2);
    // Continuous transmit from sleep
    go(MODE_TX);
    k = OSC_WAKE_CYC + TX_BASE_CYC + (RAMPC * RAMP_NUM + RAMP_DEN - 1) / RAMP_DEN + BITC / 2;
    chk(n >= k && n <= k + 8, 1);
    chk(lk.mode_settled_flag, 1);
    @(posedge lk.bit_clock_pin);
    @(negedge clk_i);
    n = 0;
    while (lk.bit_clock_pin === 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk(n, BITC / 2);
    base = btakes;
    for (int v = 0; v < 2; v++) begin
      @(negedge clk_i);
      txb = v[0];
      repeat (3) @(posedge lk.bit_clock_pin);
      @(negedge lk.bit_clock_pin);
      @(negedge clk_i);
      chk({lk.data_host_oe, lk.serial_data_pin}, {1'b1, v[0]});
    end
    // One data update per rising bit clock edge, six edges above
    chk(btakes - base, 6);
    // Packet transmit: preamble alternates, bytes held until the trigger
    sleep();
    pkt = 1'b1;
    cont = 1'b0;
    base = takes;
    go(MODE_TX);
    k = 0;
    for (int b = 0; b < 16; b++) begin
      @(posedge lk.bit_clock_pin);
      #1;
      if (b > 0 && lk.serial_data_pin === pb) k++;
      pb = lk.serial_data_pin;
    end
    chk(k, 0);
    chk(takes - base, 0);
    @(negedge clk_i);
    trig = 1'b1;
    n = 0;
    while (taken !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk(n < 3000, 1);
    trig = 1'b0;
    // Receive with AFC and bit synchronizer
    sleep();
    pkt = 1'b0;
    cont = 1'b1;
    bsync = 1'b1;
    go(MODE_RX);
    chk(n >= FE_DELAY_CYC + RELOCK_CYC + AFC_BITS * BITC && n < 30000, 1);
    chk(lk.mode_settled_flag, 1);
    k = 0;
    while (rxv !== 1'b1 && k < 40) begin
      @(posedge lk.bit_clock_pin);
      @(negedge clk_i);
      k++;
    end
    chk(k >= SYNC_LOCK_BITS && k <= SYNC_LOCK_BITS + 1, 1);
    // Receive hop, then restart without the synchronizer in on-off keying
    bsync = 1'b0;
    ook = 1'b1;
    do_hop({MODE_RX, MODE_SYNTH, MODE_RX});
    go(MODE_RX);
    // Two on-off keying filter delays at 400 kHz bandwidth, plus front end and relock
    chk(n >= FE_DELAY_CYC + 2 * ((CF_OOK_NUM * 100000 + 4 * 400 - 1) / (4 * 400)) + RELOCK_CYC && n < 30000, 1);
    chk(rxv, 1);
    for (int v = 0; v < 2; v++) begin
      @(negedge clk_i);
      rxb = v[0];
      #1;
      chk(rxd, v);
    end
    // Transmit hop steps through receive
    go(MODE_TX);
    chk(lk.transmit_ready_flag, 1);
    do_hop({MODE_TX, MODE_RX, MODE_TX});
    results();
  end
endmodule
